// ---- dv/fault_log_model.sv ----
// fault history memory that sits on the decoder's log port
// assumes a combinational lookup on the decoder's clock
`timescale 1ns/1ps
`default_nettype none
module fault_log_model (
  input  wire logic [7:0] index_i, // byte index from the decoder
  output logic      [7:0] byte_o   // stored log byte
);
  // index-keyed pattern, so a skipped or repeated byte shows up
  assign byte_o = index_i ^ 8'ha5;
endmodule
`default_nettype wire

// ---- dv/mfr_cmd_assertions.sv ----
// timing checker for the upper command decoder, bound to its ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module mfr_cmd_checker (
  input wire logic       clk_i, rst_i, txn_valid_i, rsp_valid_o,
  input wire logic [7:0] txn_code_i, history_index_o, pwm_mode_byte_i,
  input wire logic [7:0] pwm_phase_config_o, cml_fault_bits_o,
  input wire logic [2:0] txn_kind_i,
  input wire logic [1:0] comp_range_o,
  input wire logic       history_save_o, fault_off_o, history_erase_o,
  input wire logic       soft_reset_o, cml_fault_set_o, ilim_high_range_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // code of a send-byte request, zero when none is offered
  wire logic [7:0] sc = (txn_valid_i && txn_kind_i == 3'h0) ? txn_code_i : 8'h00;
  a_save_fault_pair: assert property (sc == 8'hea |=>
    history_save_o && fault_off_o && history_index_o == 8'h00) else $error("save pulse bad");
  a_erase_pulse_once: assert property (sc == 8'hec ##1 sc != 8'hec |->
    history_erase_o ##1 !history_erase_o) else $error("erase pulse bad");
  a_iin_read_answer: assert property (txn_valid_i && txn_code_i == 8'hed &&
    txn_kind_i == 3'h4 |=> rsp_valid_o) else $error("no answer to current read");
  a_history_index_step: assert property (txn_valid_i && txn_code_i == 8'hee &&
    txn_kind_i == 3'h3 |=> history_index_o == $past(history_index_o) + 8'h01)
    else $error("history index did not step");
  a_reset_pulse_once: assert property (sc == 8'hfd ##1 sc != 8'hfd |->
    soft_reset_o ##1 !soft_reset_o) else $error("soft reset pulse bad");
  a_cml_bit_six: assert property (cml_fault_set_o |->
    cml_fault_bits_o == 8'h40) else $error("cml bits wrong");
  a_comp_range_field: assert property (
    comp_range_o == pwm_phase_config_o[6:5]) else $error("comp range mismatch");
  a_ilim_range_bit: assert property (
    ilim_high_range_o == pwm_mode_byte_i[7]) else $error("ilim range mismatch");
endmodule
bind mfr_cmd_decoder mfr_cmd_checker chk (.*);
`default_nettype wire

// ---- dv/pmbus_mfr_command_decoder_bench.sv ----
// self-checking bench for the upper command decoder
// assumes the fault log model on the history port and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module pmbus_mfr_command_decoder_bench;
  import mfr_cmd_pkg::*;
  logic clk_i = 0, rst_i = 1, txn_valid_i = 0, txn_page_i = 0, die_temp_valid_i = 0;
  logic peak_clear_i = 0, nvm_save_all_i = 0, nvm_restore_all_i = 0, history_lock_set_i = 0;
  logic [7:0] txn_code_i = 0, family_status_i = 8'h5c, pwm_mode_byte_i = 8'h80;
  logic [2:0] txn_kind_i = 0;
  logic [15:0] txn_data_i = 0, iin_ch0_i = 16'hd234, iin_ch1_i = 16'h0a01, die_temp_i = 0;
  logic [7:0] history_byte_i, history_index_o, cml_fault_bits_o, pwm_phase_config_o;
  logic [7:0] rail_addr_ch0_o, rail_addr_ch1_o;
  logic txn_hit_o, rsp_valid_o, history_locked_o, history_save_o, history_erase_o;
  logic fault_off_o, soft_reset_o, cml_fault_set_o, nvm_mismatch_o, ilim_high_range_o;
  logic [15:0] rsp_data_o, sense_tc_ch0_o, sense_tc_ch1_o, ext_slope_ch0_o, ext_slope_ch1_o;
  logic [15:0] ext_offset_ch0_o, ext_offset_ch1_o;
  logic [1:0] comp_range_o;
  logic [15:0] smp [3] = '{16'h0010, 16'h0020, 16'hf830}; // raw 0xf830 is only 24
  logic [7:0] bad [2] = '{8'heb, 8'hed}; // unpublished, then read-only
  logic [15:0] rst_val [5] = '{16'h0010, 16'h0f3c, 16'h4000, 16'h8000, 16'h0080};
  logic [7:0] rst_code [5] = '{8'hf5, 8'hf6, 8'hf8, 8'hf9, 8'hfa};
  int n_errors = 0, checks_done = 0;
  mfr_cmd_decoder dut (.*);
  fault_log_model log_mem (.index_i(history_index_o), .byte_o(history_byte_i));
  always #2.5 clk_i = ~clk_i;
  // ****
  // access tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one-cycle request; returns just after the taking edge settles
  task automatic txn(input logic [7:0] c, input logic [2:0] k, input logic [15:0] d,
                     input logic p);
    @(posedge clk_i);
    txn_valid_i <= 1'b1;
    txn_code_i <= c;
    txn_kind_i <= k;
    txn_data_i <= d;
    txn_page_i <= p;
    @(posedge clk_i);
    txn_valid_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [2:0] k, input logic p,
                    input logic [15:0] e);
    txn(c, k, 16'h0000, p);
    chk("rsp_valid_o", 16'(rsp_valid_o), 16'h0001);
    chk("rsp_data_o", rsp_data_o, e);
  endtask
  // hang guard: a run this long counts as a failure
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values of every stored register, both pages; byte codes read as bytes
    for (int p = 0; p < 2; p++) begin
      foreach (rst_code[i]) begin
        rd(rst_code[i], (i == 0 || i == 4) ? 3'h3 : 3'h4, p[0], rst_val[i]);
      end
    end
    chk("sense_tc_ch1_o", sense_tc_ch1_o, 16'h0f3c);
    chk("ext_slope_ch0_o", ext_slope_ch0_o, 16'h4000);
    chk("ext_slope_ch1_o", ext_slope_ch1_o, 16'h4000);
    chk("rail_addr_ch0_o", 16'(rail_addr_ch0_o), 16'h0080);
    rd(8'hed, 3'h4, 1'b1, 16'h0a01);
    rd(8'hed, 3'h4, 1'b0, 16'hd234);
    rd(8'hef, 3'h3, 1'b0, 16'h005c);
    rd(8'hf1, 3'h4, 1'b0, 16'h0000);
    // peak must compare by value, not raw word; clear shares the first sample
    foreach (smp[i]) begin
      @(posedge clk_i);
      die_temp_i <= smp[i];
      die_temp_valid_i <= 1'b1;
      peak_clear_i <= (i == 0);
    end
    @(posedge clk_i);
    die_temp_valid_i <= 1'b0;
    peak_clear_i <= 1'b0;
    rd(8'hf4, 3'h4, 1'b1, 16'h0020);
    for (int i = 0; i < 3; i++) rd(8'hee, 3'h3, 1'b0, {8'h00, 8'(i) ^ 8'ha5});
    // save must restart the record from byte zero
    txn(8'hea, 3'h0, 16'h0000, 1'b0);
    chk("history_save_o", 16'(history_save_o & fault_off_o), 16'h0001);
    rd(8'hee, 3'h3, 1'b0, 16'h00a5);
    @(posedge clk_i) history_lock_set_i <= 1'b1;
    @(posedge clk_i) history_lock_set_i <= 1'b0;
    #1 chk("history_locked_o", 16'(history_locked_o), 16'h0001);
    txn(8'hec, 3'h0, 16'h0000, 1'b0);
    chk("erase_lock", 16'({history_erase_o, history_locked_o}), 16'h0002);
    // only fault injection; every other write uses a published code
    foreach (bad[i]) begin
      txn(bad[i], 3'h2, 16'h0012, 1'b0);
      chk("cml_fault_bits_o", 16'({cml_fault_set_o, cml_fault_bits_o}), 16'h0140);
    end
    txn(8'hf9, 3'h2, 16'h1234, 1'b1);
    chk("ext_offset_chN_o", ext_offset_ch1_o ^ ext_offset_ch0_o, 16'h9234);
    txn(8'hf6, 3'h2, 16'h1357, 1'b0);
    chk("sense_tc_ch0_o", sense_tc_ch0_o, 16'h1357);
    txn(8'hf5, 3'h1, 16'h0060, 1'b0);
    chk("comp_range_o", 16'(comp_range_o), 16'h0003);
    chk("ilim_high_range_o", 16'(ilim_high_range_o), 16'h0001);
    @(posedge clk_i) pwm_mode_byte_i <= 8'h7f;
    #1 chk("ilim_high_range_o", 16'(ilim_high_range_o), 16'h0000);
    txn(8'hf0, 3'h0, 16'h0000, 1'b0);
    chk("nvm_mismatch_o", 16'(nvm_mismatch_o), 16'h0001);
    @(posedge clk_i) nvm_save_all_i <= 1'b1;
    @(posedge clk_i) nvm_save_all_i <= 1'b0;
    txn(8'hf0, 3'h0, 16'h0000, 1'b0);
    chk("nvm_mismatch_o", 16'(nvm_mismatch_o), 16'h0000);
    txn(8'hf9, 3'h2, 16'h5555, 1'b1);
    @(posedge clk_i) nvm_restore_all_i <= 1'b1;
    @(posedge clk_i) nvm_restore_all_i <= 1'b0;
    rd(8'hf9, 3'h4, 1'b1, 16'h1234);
    txn(8'hfa, 3'h1, 16'h0033, 1'b1);
    chk("rail_addr_ch1_o", 16'(rail_addr_ch1_o), 16'h0033);
    txn(8'hfd, 3'h0, 16'h0000, 1'b0);
    chk("soft_reset_o", 16'(soft_reset_o), 16'h0001);
    repeat (2) @(posedge clk_i);
    rd(8'hfa, 3'h3, 1'b1, 16'h0080);
    chk("rail_addr_ch1_o", 16'(rail_addr_ch1_o), 16'h0080);
    stop_test;
  end
endmodule
`default_nettype wire

// ---- logic/mfr_cmd_decoder.sv ----
// decoder and executor for the upper manufacturer command codes
// assumes a protocol layer on clk_i delivering one transaction per pulse,
// telemetry words arriving already in linear_11bit_format on the same clock
//
// Contract
// - save-history command stores log, faults channel off
// - erase-history command initialises block, releases lock
// - input current read per page, linear format
// - history reads deliver successive bytes
// - family status bits readable
// - compare command checks working against nvm copy
// - unpaged peak die temperature since clear
// - unpaged pwm config, reset 0x10, bits 5-6
// - paged temp coefficient, default 0x0f3c, saved
// - paged external sensor slope, default 0x4000
// - paged external sensor offset, default 0x8000
// - paged shared rail address, default 0x80
// - soft reset command resets without power loss
// - save-all stores, restore-all reloads nvm commands
// - unpublished reads have no side effect
// - unpublished write sets communication fault bit 6
// - linear exponent is 5-bit field 15:11
// - unsigned linear: whole word, exponent -12
// - integer word is plain unsigned 16 bits
// - factory-set and undefined defaults handled
// - pwm mode bit 7 picks current-limit range
`timescale 1ns/1ps
`default_nettype none

module mfr_cmd_decoder
  import mfr_cmd_pkg::*;
(
  input  wire logic        clk_i,               // 200 MHz system clock
  input  wire logic        rst_i,               // synchronous, active high
  // transaction port from the protocol layer
  input  wire logic        txn_valid_i,         // one-cycle pulse per command
  input  wire logic [7:0]  txn_code_i,          // command code
  input  wire logic [2:0]  txn_kind_i,          // txn_kind_t
  input  wire logic [15:0] txn_data_i,          // write data, byte in low bits
  input  wire logic        txn_page_i,          // selected channel
  output logic             txn_hit_o,           // code lies in this block's range
  output logic             rsp_valid_o,         // one-cycle pulse, read answer
  output logic [15:0]      rsp_data_o,          // read data, byte in low bits
  // telemetry and status inputs, same clock
  input  wire logic [15:0] iin_ch0_i,           // input current, channel 0
  input  wire logic [15:0] iin_ch1_i,           // input current, channel 1
  input  wire logic [15:0] die_temp_i,          // die temperature sample
  input  wire logic        die_temp_valid_i,    // new sample pulse
  input  wire logic        peak_clear_i,        // peak clear command pulse
  input  wire logic [7:0]  family_status_i,     // shared status bits
  input  wire logic [7:0]  pwm_mode_byte_i,     // pwm mode byte of sibling decoder
  input  wire logic        nvm_save_all_i,      // save-all command pulse
  input  wire logic        nvm_restore_all_i,   // restore-all command pulse
  input  wire logic        history_lock_set_i,  // log engine locked its block
  input  wire logic [7:0]  history_byte_i,      // log byte at history_index_o
  // actions and configuration outputs
  output logic [7:0]       history_index_o,     // byte index into the log
  output logic             history_locked_o,    // history lock held
  output logic             history_save_o,      // pulse, copy log ram to nvm
  output logic             history_erase_o,     // pulse, initialise log block
  output logic             fault_off_o,         // pulse, act as channel faulted
  output logic             soft_reset_o,        // pulse, full device reset
  output logic             cml_fault_set_o,     // pulse, set cml status bit
  output logic [7:0]       cml_fault_bits_o,    // which cml bit to set
  output logic             nvm_mismatch_o,      // last compare found differences
  output logic [1:0]       comp_range_o,        // compensation range select
  output logic             ilim_high_range_o,   // 37.5 to 70 mV range selected
  output logic [7:0]       pwm_phase_config_o,  // full pwm config byte
  output logic [15:0]      sense_tc_ch0_o,      // temperature coefficient ch0
  output logic [15:0]      sense_tc_ch1_o,      // temperature coefficient ch1
  output logic [15:0]      ext_slope_ch0_o,     // sensor slope ch0
  output logic [15:0]      ext_slope_ch1_o,     // sensor slope ch1
  output logic [15:0]      ext_offset_ch0_o,    // sensor offset ch0
  output logic [15:0]      ext_offset_ch1_o,    // sensor offset ch1
  output logic [7:0]       rail_addr_ch0_o,     // shared rail address ch0
  output logic [7:0]       rail_addr_ch1_o      // shared rail address ch1
);

  // ****************************************************************
  // working and nonvolatile copies of configuration
  // ****************************************************************
  logic [7:0]  pwm_phase_config_reg;             // working pwm config
  logic [15:0] sense_tc_reg   [PAGES];           // working, per page
  logic [15:0] ext_slope_reg  [PAGES];
  logic [15:0] ext_offset_reg [PAGES];
  logic [7:0]  rail_addr_reg  [PAGES];
  logic [7:0]  nv_pwm_reg;                       // nvm image of pwm config
  logic [15:0] nv_tc_reg      [PAGES];           // nvm images, per page
  logic [15:0] nv_slope_reg   [PAGES];
  logic [15:0] nv_offset_reg  [PAGES];
  logic [7:0]  nv_rail_reg    [PAGES];

  // ****************************************************************
  // other state
  // ****************************************************************
  logic [15:0] die_peak_reg;                     // highest die temp seen
  logic        die_peak_seen_reg;                // peak holds a real sample
  logic        history_locked_reg;               // log lock flag
  logic [7:0]  history_index_reg;                // next log byte to deliver
  logic        nvm_mismatch_reg;                 // compare result
  logic        rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic [15:0] rsp_data_next;
  logic        save_pulse_reg;
  logic        erase_pulse_reg;
  logic        soft_reset_reg;
  logic        cml_pulse_reg;
  logic        nvm_differs;                      // working differs from image

  // ****************************************************************
  // transaction decode
  // ****************************************************************
  txn_kind_t kind;
  logic      in_range;
  logic      is_send;
  logic      is_write;
  logic      is_read;
  logic      is_word;
  logic      published;
  logic      writable;
  logic      pg;

  assign kind     = txn_kind_t'(txn_kind_i);
  assign in_range = (txn_code_i >= CMD_RANGE_LOW) && (txn_code_i <= CMD_RANGE_HIGH);
  assign is_send  = txn_valid_i && in_range && (kind == KIND_SEND_BYTE);
  assign is_write = txn_valid_i && in_range &&
                    ((kind == KIND_WRITE_BYTE) || (kind == KIND_WRITE_WORD));
  assign is_read  = txn_valid_i && in_range &&
                    ((kind == KIND_READ_BYTE) || (kind == KIND_READ_WORD));
  assign is_word  = (kind == KIND_WRITE_WORD);
  assign pg       = txn_page_i;
  assign txn_hit_o = txn_valid_i && in_range;

  // published codes of the range
  always_comb begin
    case (txn_code_i)
      CMD_FAULT_HISTORY_SAVE, CMD_FAULT_HISTORY_ERASE, CMD_INPUT_CURRENT,
      CMD_FAULT_HISTORY_READ, CMD_FAMILY_STATUS, CMD_NVM_COMPARE,
      CMD_DIE_TEMP_PEAK, CMD_PWM_PHASE_CONFIG, CMD_SENSE_TEMP_COEFF,
      CMD_EXT_TEMP_SLOPE, CMD_EXT_TEMP_OFFSET, CMD_SHARED_RAIL_ADDRESS,
      CMD_SOFT_RESET: published = 1'b1;
      default:        published = 1'b0;
    endcase
  end

  // codes that accept a data write
  always_comb begin
    case (txn_code_i)
      CMD_PWM_PHASE_CONFIG, CMD_SENSE_TEMP_COEFF, CMD_EXT_TEMP_SLOPE,
      CMD_EXT_TEMP_OFFSET, CMD_SHARED_RAIL_ADDRESS: writable = 1'b1;
      default:                                      writable = 1'b0;
    endcase
  end

  // ****************************************************************
  // configuration registers with nvm save and restore
  // ****************************************************************
  // restore wins over a same-cycle write; soft reset reloads the nvm images like restore-all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_phase_config_reg <= PWM_PHASE_CONFIG_RST;
      for (int p = 0; p < PAGES; p++) begin
        sense_tc_reg[p]   <= SENSE_TEMP_COEFF_RST;
        ext_slope_reg[p]  <= EXT_TEMP_SLOPE_RST;
        ext_offset_reg[p] <= EXT_TEMP_OFFSET_RST;
        rail_addr_reg[p]  <= SHARED_RAIL_ADDRESS_RST;
      end
    end else if (nvm_restore_all_i || soft_reset_reg) begin
      // reload every nvm-backed command from its image
      pwm_phase_config_reg <= nv_pwm_reg;
      for (int p = 0; p < PAGES; p++) begin
        sense_tc_reg[p]   <= nv_tc_reg[p];
        ext_slope_reg[p]  <= nv_slope_reg[p];
        ext_offset_reg[p] <= nv_offset_reg[p];
        rail_addr_reg[p]  <= nv_rail_reg[p];
      end
    end else if (is_write) begin
      // byte commands take a byte write, word commands a word write
      case (txn_code_i)
        CMD_PWM_PHASE_CONFIG: begin
          if (!is_word) pwm_phase_config_reg <= txn_data_i[7:0];
        end
        CMD_SENSE_TEMP_COEFF: begin
          if (is_word) sense_tc_reg[pg] <= txn_data_i;
        end
        CMD_EXT_TEMP_SLOPE: begin
          if (is_word) ext_slope_reg[pg] <= txn_data_i;
        end
        CMD_EXT_TEMP_OFFSET: begin
          if (is_word) ext_offset_reg[pg] <= txn_data_i;
        end
        CMD_SHARED_RAIL_ADDRESS: begin
          if (!is_word) rail_addr_reg[pg] <= txn_data_i[7:0];
        end
        default: begin
          // read-only and unknown codes store nothing
        end
      endcase
    end
  end

  // nvm images; reset models a freshly programmed part
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_pwm_reg <= PWM_PHASE_CONFIG_RST;
      for (int p = 0; p < PAGES; p++) begin
        nv_tc_reg[p]     <= SENSE_TEMP_COEFF_RST;
        nv_slope_reg[p]  <= EXT_TEMP_SLOPE_RST;
        nv_offset_reg[p] <= EXT_TEMP_OFFSET_RST;
        nv_rail_reg[p]   <= SHARED_RAIL_ADDRESS_RST;
      end
    end else if (nvm_save_all_i) begin
      nv_pwm_reg <= pwm_phase_config_reg;
      for (int p = 0; p < PAGES; p++) begin
        nv_tc_reg[p]     <= sense_tc_reg[p];
        nv_slope_reg[p]  <= ext_slope_reg[p];
        nv_offset_reg[p] <= ext_offset_reg[p];
        nv_rail_reg[p]   <= rail_addr_reg[p];
      end
    end
  end

  // ****************************************************************
  // nvm compare
  // ****************************************************************
  // full compare in one cycle; cheap at this register count
  always_comb begin
    nvm_differs = (pwm_phase_config_reg != nv_pwm_reg);
    for (int p = 0; p < PAGES; p++) begin
      if ((sense_tc_reg[p] != nv_tc_reg[p]) || (ext_slope_reg[p] != nv_slope_reg[p]) ||
          (ext_offset_reg[p] != nv_offset_reg[p]) || (rail_addr_reg[p] != nv_rail_reg[p]))
        nvm_differs = 1'b1;
    end
  end

  // result holds until the next compare command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_mismatch_reg <= 1'b0;
    end else if (is_send && (txn_code_i == CMD_NVM_COMPARE)) begin
      nvm_mismatch_reg <= nvm_differs;
    end
  end

  // ****************************************************************
  // peak die temperature
  // ****************************************************************
  // a sample arriving with the clear starts the new peak, so none is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      die_peak_reg      <= 16'h0000;   // undefined until first sample
      die_peak_seen_reg <= 1'b0;
    end else if (die_temp_valid_i &&
                 (peak_clear_i || !die_peak_seen_reg ||
                  (linear_11bit_to_fixed(die_temp_i) >
                   linear_11bit_to_fixed(die_peak_reg)))) begin
      die_peak_reg      <= die_temp_i;
      die_peak_seen_reg <= 1'b1;
    end else if (peak_clear_i) begin
      die_peak_seen_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // fault history lock and readout index
  // ****************************************************************
  // lock set by the log engine wins over an erase in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      history_locked_reg <= 1'b0;
    end else if (history_lock_set_i) begin
      history_locked_reg <= 1'b1;
    end else if (is_send && (txn_code_i == CMD_FAULT_HISTORY_ERASE)) begin
      history_locked_reg <= 1'b0;
    end
  end

  // each readout advances one byte; save and erase restart the record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      history_index_reg <= 8'h00;
    end else if (is_send && ((txn_code_i == CMD_FAULT_HISTORY_SAVE) ||
                             (txn_code_i == CMD_FAULT_HISTORY_ERASE))) begin
      history_index_reg <= 8'h00;
    end else if (is_read && (txn_code_i == CMD_FAULT_HISTORY_READ)) begin
      if (history_index_reg == FAULT_HISTORY_LAST)
        history_index_reg <= 8'h00;
      else
        history_index_reg <= history_index_reg + 8'h01;
    end
  end

  // ****************************************************************
  // send-byte actions and fault flag pulses
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      save_pulse_reg  <= 1'b0;
      erase_pulse_reg <= 1'b0;
      soft_reset_reg  <= 1'b0;
      cml_pulse_reg   <= 1'b0;
    end else begin
      save_pulse_reg  <= is_send && (txn_code_i == CMD_FAULT_HISTORY_SAVE);
      erase_pulse_reg <= is_send && (txn_code_i == CMD_FAULT_HISTORY_ERASE);
      soft_reset_reg  <= is_send && (txn_code_i == CMD_SOFT_RESET);
      // a write to a code without writable data raises the cml bit
      cml_pulse_reg   <= is_write && (!published || !writable);
    end
  end

  // ****************************************************************
  // read answers
  // ****************************************************************
  // reads only select data; no read touches state except history
  always_comb begin
    case (txn_code_i)
      CMD_INPUT_CURRENT:       rsp_data_next = pg ? iin_ch1_i : iin_ch0_i;
      CMD_FAULT_HISTORY_READ:  rsp_data_next = {8'h00, history_byte_i};
      CMD_FAMILY_STATUS:       rsp_data_next = {8'h00, family_status_i};
      CMD_DIE_TEMP_PEAK:       rsp_data_next = die_peak_reg;
      CMD_PWM_PHASE_CONFIG:    rsp_data_next = {8'h00, pwm_phase_config_reg};
      CMD_SENSE_TEMP_COEFF:    rsp_data_next = integer_word_value(sense_tc_reg[pg]);
      CMD_EXT_TEMP_SLOPE:      rsp_data_next = ext_slope_reg[pg];
      CMD_EXT_TEMP_OFFSET:     rsp_data_next = ext_offset_reg[pg];
      CMD_SHARED_RAIL_ADDRESS: rsp_data_next = {8'h00, rail_addr_reg[pg]};
      default:                 rsp_data_next = 16'h0000;
    endcase
  end

  // answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 16'h0000;
    end else begin
      rsp_valid_reg <= is_read;
      if (is_read)
        rsp_data_reg <= rsp_data_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rsp_valid_o        = rsp_valid_reg;
  assign rsp_data_o         = rsp_data_reg;
  assign history_index_o    = history_index_reg;
  assign history_locked_o   = history_locked_reg;
  assign history_save_o     = save_pulse_reg;
  assign fault_off_o        = save_pulse_reg;
  assign history_erase_o    = erase_pulse_reg;
  assign soft_reset_o       = soft_reset_reg;
  assign cml_fault_set_o    = cml_pulse_reg;
  assign cml_fault_bits_o   = 8'(cml_pulse_reg) << CML_UNPUB_WRITE_BIT;
  assign nvm_mismatch_o     = nvm_mismatch_reg;
  assign comp_range_o       = pwm_phase_config_reg[COMP_RANGE_LSB +: 2];
  assign ilim_high_range_o  = pwm_mode_byte_i[ILIM_RANGE_BIT];
  assign pwm_phase_config_o = pwm_phase_config_reg;
  assign sense_tc_ch0_o     = sense_tc_reg[0];
  assign sense_tc_ch1_o     = sense_tc_reg[1];
  assign ext_slope_ch0_o    = ext_slope_reg[0];
  assign ext_slope_ch1_o    = ext_slope_reg[1];
  assign ext_offset_ch0_o   = ext_offset_reg[0];
  assign ext_offset_ch1_o   = ext_offset_reg[1];
  assign rail_addr_ch0_o    = rail_addr_reg[0];
  assign rail_addr_ch1_o    = rail_addr_reg[1];

endmodule

`default_nettype wire

// ---- logic/mfr_cmd_pkg.sv ----
// shared constants for the upper manufacturer command decoder
// assumes a pmbus protocol layer on the same clock hands over whole transactions
package mfr_cmd_pkg;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_FAULT_HISTORY_SAVE   = 8'hea;
  localparam logic [7:0] CMD_FAULT_HISTORY_ERASE  = 8'hec;
  localparam logic [7:0] CMD_INPUT_CURRENT        = 8'hed;
  localparam logic [7:0] CMD_FAULT_HISTORY_READ   = 8'hee;
  localparam logic [7:0] CMD_FAMILY_STATUS        = 8'hef;
  localparam logic [7:0] CMD_NVM_COMPARE          = 8'hf0;
  localparam logic [7:0] CMD_DIE_TEMP_PEAK        = 8'hf4;
  localparam logic [7:0] CMD_PWM_PHASE_CONFIG     = 8'hf5;
  localparam logic [7:0] CMD_SENSE_TEMP_COEFF     = 8'hf6;
  localparam logic [7:0] CMD_EXT_TEMP_SLOPE       = 8'hf8;
  localparam logic [7:0] CMD_EXT_TEMP_OFFSET      = 8'hf9;
  localparam logic [7:0] CMD_SHARED_RAIL_ADDRESS  = 8'hfa;
  localparam logic [7:0] CMD_SOFT_RESET           = 8'hfd;
  localparam logic [7:0] CMD_RANGE_LOW            = 8'hea;
  localparam logic [7:0] CMD_RANGE_HIGH           = 8'hfd;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0]  PWM_PHASE_CONFIG_RST    = 8'h10;
  localparam logic [15:0] SENSE_TEMP_COEFF_RST    = 16'h0f3c;
  localparam logic [15:0] EXT_TEMP_SLOPE_RST      = 16'h4000;
  localparam logic [15:0] EXT_TEMP_OFFSET_RST     = 16'h8000;
  localparam logic [7:0]  SHARED_RAIL_ADDRESS_RST = 8'h80;
  localparam int          COMP_RANGE_LSB          = 5;  // bits 5 and 6
  localparam int          ILIM_RANGE_BIT          = 7;  // pwm mode byte
  localparam int          CML_UNPUB_WRITE_BIT     = 6;
  localparam int          PAGES                   = 2;
  localparam logic [7:0]  FAULT_HISTORY_LAST      = 8'hff; // last byte index

  // ****************************************************************
  // transaction kinds from the protocol layer
  // ****************************************************************
  typedef enum logic [2:0] {
    KIND_SEND_BYTE,
    KIND_WRITE_BYTE,
    KIND_WRITE_WORD,
    KIND_READ_BYTE,
    KIND_READ_WORD
  } txn_kind_t;

  // ****************************************************************
  // numeric formats, linear ones scaled to a common 2^-16 fixed point
  // ****************************************************************
  // exponent in 15:11, two's complement mantissa in 10:0
  function automatic logic signed [47:0] linear_11bit_to_fixed(input logic [15:0] w);
    logic [4:0] shift;
    shift = {~w[15], w[14:11]};                      // exponent plus 16
    return $signed({{37{w[10]}}, w[10:0]}) <<< shift; // signed mantissa
  endfunction

  // whole word unsigned, exponent fixed at -12
  function automatic logic signed [47:0] linear_unsigned_to_fixed(input logic [15:0] w);
    return $signed({28'h0, w, 4'h0});
  endfunction

  // whole word as unsigned integer
  function automatic logic [15:0] integer_word_value(input logic [15:0] w);
    return w;
  endfunction

endpackage
